// ### lut_datapath_map.vh
// Register offsets, field positions and reset values of the table datapath
`ifndef LUT_DATAPATH_MAP_VH
`define LUT_DATAPATH_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CONFIG        8'h00
`define OFS_UPPER_TABLE   8'h04
`define OFS_LOWER_TABLE   8'h08
`define OFS_STATUS        8'h0c

// ----------------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------------
`define CFG_UPPER_MEM     0
`define CFG_LOWER_MEM     1
`define CFG_RIPPLE        2
`define CFG_SUB_LO        3
`define CFG_SUB_HI        4
`define CFG_COMB_LO       5
`define CFG_COMB_HI       6
`define CFG_FAST_EN       7
`define CFG_FAST_INV      8
`define CFG_CIN_LO        9
`define CFG_CIN_HI        10
`define CFG_RIPPLE_CARRY_OUT_ROUTE    11
`define CFG_RIPPLE_CARRY_OUT_PIN      12
`define CFG_GATE_SEL      13
`define CFG_WIDTH         14

// ----------------------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------------------
`define SUB_ADDSUB        2'h0
`define SUB_COUNTER       2'h1
`define SUB_MULT          2'h2
`define SUB_COMPARE       2'h3
`define COMB_OFF          2'h0
`define COMB_MUX          2'h1
`define COMB_XOR          2'h2
`define CIN_ROUTING       2'h0
`define CIN_B4            2'h1
`define CIN_ONE           2'h2
`define CIN_ZERO          2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CONFIG_RESET      14'h0000
`define TABLE_RESET       32'h00000000

`endif

// ### half_table.v
// One 32-bit half table: configuration load, 16x2 memory write, combinational reads
`timescale 1ns/1ps
`include "lut_datapath_map.vh"
module half_table (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // Configuration load from the register bus
    input  wire        loadEn,
    input  wire [31:0] loadData,
    // Memory write port
    input  wire        memWe,
    input  wire [3:0]  memAddr,
    input  wire [1:0]  memData,
    // Five-input logic read
    input  wire [4:0]  logicAddr,
    // Results
    output wire [31:0] contents,
    output wire        logicBit,
    output wire [1:0]  memBits
);

    reg [31:0] cells_r;
    reg [31:0] cells_nxt;

    // Bus load wins over a memory write in the same cycle
    always @* begin
        cells_nxt = cells_r;
        if (loadEn) begin
            cells_nxt = loadData;
        end else if (memWe) begin
            cells_nxt[{1'b0, memAddr}] = memData[0];
            cells_nxt[{1'b1, memAddr}] = memData[1];
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cells_r <= `TABLE_RESET;
        end else begin
            cells_r <= cells_nxt;
        end
    end

    assign logicBit = cells_r[logicAddr];
    assign memBits  = {cells_r[{1'b1, memAddr}], cells_r[{1'b0, memAddr}]};
    assign contents = cells_r;

endmodule // half_table

// ### ripple_slice.v
// One quarter-table ripple bit: propagate/generate result and ripple out
`timescale 1ns/1ps
module ripple_slice (
    // Operands
    input  wire opA,
    input  wire opB,
    input  wire rippleIn,
    // Comparator behaviour
    input  wire compare,
    // Results
    output wire resultBit,
    output wire rippleOut
);

    wire propagate;
    wire generate_;

    assign propagate = opA ^ opB;
    assign generate_ = opA & opB;
    assign resultBit = compare ? propagate : (propagate ^ rippleIn);
    assign rippleOut = compare ? (rippleIn | propagate)
                               : (generate_ | (propagate & rippleIn));

endmodule // ripple_slice

// ### lut_datapath.v
// Table datapath of one programmable_function_unit with APB configuration
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "lut_datapath_map.vh"

// Operation
// - Mux combine: upper result when side input high, else lower result.
// - Xor combine: upper xor lower xor side input.
// - Nand result: nand of upper, lower and side input.
// - Mux and xor share the combine output; nand available only in mux or xor mode.
// - Combining only with both halves five-input; half results stay visible.
// - Six-input function: same five inputs on both sides, sixth on side input.
// - Ripple chains quarter to quarter; bottom carry from selectable source.
// - Operands on low a/b inputs; top ripple to carry out and/or output 4.
// - Add/sub slices make propagate-or-generate carry and sum; a4 picks subtract.
// - Counter: low a-inputs plus or minus one; a4 picks direction.
// - Multiplier: partial product plus carry plus multiplicand when a4 set.
// - Comparator forces carry in 0; carry out 1 when operands differ.
// - Each half is an independent 16x2 memory or five-input function.
// - 16x4 memory: address low inputs, write data port, a4/b4 enables.
// - Upper writes need a4 and gate; lower writes need b4 and gate.
// - One common write gate for both halves in memory mode.
// - Two 32-bit halves; quarters 0..3 drive results 0..3.
// - Ripple mode excludes logic and memory use of both halves.
// - Side input disabled by default, polarity programmable.
module lut_datapath (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output wire [31:0] prdata,
    // Fabric inputs
    input  wire [4:0]  aIn,
    input  wire [4:0]  bIn,
    input  wire [3:0]  writeDataInputs,
    input  wire        fastSideInput,
    input  wire        rippleCarryIn,
    // Fabric outputs
    output wire [3:0]  tableOut,
    output wire        output4,
    output wire        rippleCarryOut
);

    // ------------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------------
    reg  [`CFG_WIDTH-1:0] config_r;
    reg  [31:0]           rdata_r;
    wire                  setup;
    wire                  access;
    wire                  hitConfig;
    wire                  hitUpper;
    wire                  hitLower;
    wire                  hitStatus;
    wire                  mapped;
    wire                  wrAccess;
    wire [31:0]           upperContents;
    wire [31:0]           lowerContents;
    wire [31:0]           statusWord;
    reg  [31:0]           readWord;

    assign setup     = psel & ~penable;
    assign access    = psel & penable;
    assign hitConfig = (paddr == `OFS_CONFIG);
    assign hitUpper  = (paddr == `OFS_UPPER_TABLE);
    assign hitLower  = (paddr == `OFS_LOWER_TABLE);
    assign hitStatus = (paddr == `OFS_STATUS);
    assign mapped    = hitConfig | hitUpper | hitLower | hitStatus;
    assign wrAccess  = access & pwrite & mapped;

    // Zero-wait slave; an unmapped address answers with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = rdata_r;

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            config_r <= `CONFIG_RESET;
        end else if (wrAccess & hitConfig) begin
            config_r <= pwdata[`CFG_WIDTH-1:0];
        end
    end

    // Read mux; unmapped offsets read zero
    always @* begin
        readWord = 32'h00000000;
        case (paddr)
            `OFS_CONFIG: begin
                readWord = {{(32-`CFG_WIDTH){1'b0}}, config_r};
            end
            `OFS_UPPER_TABLE: begin
                readWord = upperContents;
            end
            `OFS_LOWER_TABLE: begin
                readWord = lowerContents;
            end
            `OFS_STATUS: begin
                readWord = statusWord;
            end
            default: begin
                readWord = 32'h00000000;
            end
        endcase
    end

    // Read data is captured in the setup cycle so it comes from a flip-flop;
    // the access edge then finds it settled, so no wait state is needed
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h00000000;
        end else if (setup & ~pwrite) begin
            rdata_r <= readWord;
        end
    end

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    wire       rippleMode;
    wire       upperMem;
    wire       lowerMem;
    wire [1:0] subMode;
    wire [1:0] combMode;
    wire [1:0] cinSel;
    wire       fiveBoth;
    wire       muxMode;
    wire       xorMode;
    wire       fastSide;
    wire       gate;

    assign rippleMode = config_r[`CFG_RIPPLE];
    // ripple excludes memory and logic use
    assign upperMem   = config_r[`CFG_UPPER_MEM] & ~rippleMode;
    assign lowerMem   = config_r[`CFG_LOWER_MEM] & ~rippleMode;
    assign subMode    = config_r[`CFG_SUB_HI:`CFG_SUB_LO];
    assign combMode   = config_r[`CFG_COMB_HI:`CFG_COMB_LO];
    assign cinSel     = config_r[`CFG_CIN_HI:`CFG_CIN_LO];

    assign fiveBoth = ~rippleMode & ~upperMem & ~lowerMem;
    // one of mux or xor, never both
    assign muxMode  = fiveBoth & (combMode == `COMB_MUX);
    assign xorMode  = fiveBoth & (combMode == `COMB_XOR);

    // disabled side input reads as zero; polarity programmable
    assign fastSide = config_r[`CFG_FAST_EN] & (fastSideInput ^ config_r[`CFG_FAST_INV]);

    // one gate shared by both halves
    assign gate = config_r[`CFG_GATE_SEL] ? rippleCarryIn : fastSide;

    // ------------------------------------------------------------------------
    // Half tables
    // ------------------------------------------------------------------------
    wire       upperLogic;
    wire       lowerLogic;
    wire [1:0] upperMemBits;
    wire [1:0] lowerMemBits;
    wire       upperWe;
    wire       lowerWe;

    // write only when enable and gate agree
    assign upperWe = upperMem & aIn[4] & gate;
    assign lowerWe = lowerMem & bIn[4] & gate;

    // A bus load of a half table beats a fabric write in the same cycle
    // upper half holds quarters 2 and 3
    // address, data and enables of the memory
    half_table upperHalfTable (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .loadEn    (wrAccess & hitUpper),
        .loadData  (pwdata),
        .memWe     (upperWe),
        .memAddr   (aIn[3:0]),
        .memData   (writeDataInputs[3:2]),
        .logicAddr (aIn),
        .contents  (upperContents),
        .logicBit  (upperLogic),
        .memBits   (upperMemBits)
    );

    half_table lowerHalfTable (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .loadEn    (wrAccess & hitLower),
        .loadData  (pwdata),
        .memWe     (lowerWe),
        .memAddr   (bIn[3:0]),
        .memData   (writeDataInputs[1:0]),
        .logicAddr (bIn),
        .contents  (lowerContents),
        .logicBit  (lowerLogic),
        .memBits   (lowerMemBits)
    );

    // ------------------------------------------------------------------------
    // Special combining gates
    // ------------------------------------------------------------------------
    reg  combineBit;
    wire nandBit;

    // Combining is forced off unless both halves hold five-input functions
    always @* begin
        combineBit = 1'b0;
        if (muxMode) begin
            // mux; six-input function uses this path
            combineBit = fastSide ? upperLogic : lowerLogic;
        end else if (xorMode) begin
            // xor of both halves and side input
            combineBit = upperLogic ^ lowerLogic ^ fastSide;
        end else begin
            combineBit = 1'b0;
        end
    end

    // Nand reads zero with combining off, so no stale gate output leaks
    // nand of the three, present in either mode
    assign nandBit = (muxMode | xorMode) & ~(upperLogic & lowerLogic & fastSide);

    // ------------------------------------------------------------------------
    // Ripple chain
    // ------------------------------------------------------------------------
    reg  [3:0] operandB;
    reg        chainIn;
    wire [4:0] ripple;
    wire [3:0] rippleSum;
    wire       compare;
    reg        cinPort;

    assign compare = (subMode == `SUB_COMPARE);

    always @* begin
        cinPort = rippleCarryIn;
        case (cinSel)
            `CIN_ROUTING: begin
                cinPort = rippleCarryIn;
            end
            `CIN_B4: begin
                cinPort = bIn[4];
            end
            `CIN_ONE: begin
                cinPort = 1'b1;
            end
            `CIN_ZERO: begin
                cinPort = 1'b0;
            end
            default: begin
                cinPort = rippleCarryIn;
            end
        endcase
    end

    // Counter forces its own carry, so the carry-in source is ignored there
    always @* begin
        operandB = bIn[3:0];
        chainIn  = cinPort;
        case (subMode)
            `SUB_ADDSUB: begin
                operandB = aIn[4] ? ~bIn[3:0] : bIn[3:0];
                chainIn  = cinPort;
            end
            `SUB_COUNTER: begin
                // plus one, or plus all ones for minus one
                operandB = {4{aIn[4]}};
                chainIn  = ~aIn[4];
            end
            `SUB_MULT: begin
                // multiplicand added only when a4 set
                operandB = aIn[4] ? bIn[3:0] : 4'h0;
                chainIn  = cinPort;
            end
            `SUB_COMPARE: begin
                operandB = bIn[3:0];
                chainIn  = 1'b0;
            end
            default: begin
                operandB = bIn[3:0];
                chainIn  = cinPort;
            end
        endcase
    end

    assign ripple[0] = chainIn;

    genvar q;
    generate
        for (q = 0; q < 4; q = q + 1) begin : gQuarter
            ripple_slice slice (
                .opA       (aIn[q]),
                .opB       (operandB[q]),
                .rippleIn  (ripple[q]),
                .compare   (compare),
                .resultBit (rippleSum[q]),
                .rippleOut (ripple[q+1])
            );
        end
    endgenerate

    // Gated by mode so logic and memory use leave the carry routing quiet
    // top ripple to carry routing and/or output 4
    assign rippleCarryOut = rippleMode & config_r[`CFG_RIPPLE_CARRY_OUT_ROUTE] & ripple[4];
    assign output4        = rippleMode & config_r[`CFG_RIPPLE_CARRY_OUT_PIN] & ripple[4];

    // ------------------------------------------------------------------------
    // Result selection
    // ------------------------------------------------------------------------
    reg  [3:0] result;
    wire [3:0] memWord;
    wire [3:0] logicWord;

    // Each half picks memory or logic alone: one may store while the other computes
    assign memWord   = {upperMemBits, lowerMemBits};
    assign logicWord = {upperLogic, nandBit, combineBit, lowerLogic};

    always @* begin
        if (rippleMode) begin
            result = rippleSum;
        end else begin
            // half results stay usable beside the gates
            result[3] = upperMem ? memWord[3] : logicWord[3];
            result[2] = upperMem ? memWord[2] : logicWord[2];
            result[1] = lowerMem ? memWord[1] : logicWord[1];
            result[0] = lowerMem ? memWord[0] : logicWord[0];
        end
    end

    // outputs follow the selected result (memory or logic word, or ripple sum in ripple mode) with no clock
    assign tableOut = result;

    assign statusWord = {25'h0000000, ripple[4], fastSide, gate, result};

endmodule // lut_datapath

// ### lut_datapath_props.sv
// Port-level assertions for the table datapath
`timescale 1ns/1ps
module lut_datapath_props (
    // Clock and reset
    input wire        ref_clk,
    input wire        rstn,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    // Fabric
    input wire [4:0]  aIn,
    input wire [4:0]  bIn,
    input wire [3:0]  writeDataInputs,
    input wire        fastSideInput,
    input wire        rippleCarryIn,
    input wire [3:0]  tableOut,
    input wire        rippleCarryOut
);
    // Shadow of the configuration word, kept from the bus writes
    reg  [13:0] cfg_r;
    wire        apbWr  = psel && penable && pwrite;
    wire        side   = cfg_r[7] & (fastSideInput ^ cfg_r[8]);
    wire        gate   = cfg_r[13] ? rippleCarryIn : side;
    wire [1:0]  cs     = cfg_r[10:9];
    wire        ripple_carry_in    = cs == 2'h0 ? rippleCarryIn : cs == 2'h1 ? bIn[4] : cs == 2'h2;
    wire        lgc    = cfg_r[2:0] == 3'h0;
    wire        rip    = cfg_r[2];
    wire [1:0]  sub    = cfg_r[4:3];
    wire [3:0]  a      = aIn[3:0];
    wire [3:0]  b      = bIn[3:0];
    wire [4:0]  addSum = a + (b ^ {4{aIn[4]}}) + ripple_carry_in;
    wire [4:0]  mulSum = a + (aIn[4] ? b : 4'h0) + ripple_carry_in;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= 14'h0000;
        end else if (apbWr && paddr == 8'h00) begin
            cfg_r <= pwdata[13:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_mux;
        lgc && cfg_r[6:5] == 2'h1 |-> tableOut[1] == (side ? tableOut[3] : tableOut[0]);
    endproperty
    a_mux: assert property (p_mux) else $error("mux combine wrong");
    property p_xor;
        lgc && cfg_r[6:5] == 2'h2 |-> tableOut[1] == (tableOut[3] ^ tableOut[0] ^ side);
    endproperty
    a_xor: assert property (p_xor) else $error("xor combine wrong");
    property p_nand;
        lgc && ^cfg_r[6:5] |-> tableOut[2] == !(tableOut[3] && tableOut[0] && side);
    endproperty
    a_nand: assert property (p_nand) else $error("nand wrong");
    property p_add;
        rip && sub == 2'h0 |-> tableOut == addSum[3:0]
            && (!cfg_r[11] || rippleCarryOut == addSum[4]);
    endproperty
    a_add: assert property (p_add) else $error("add wrong");
    property p_cnt;
        rip && sub == 2'h1 |-> tableOut == (aIn[4] ? a - 4'h1 : a + 4'h1);
    endproperty
    a_cnt: assert property (p_cnt) else $error("count wrong");
    property p_mul;
        rip && sub == 2'h2 |-> tableOut == mulSum[3:0]
            && (!cfg_r[11] || rippleCarryOut == mulSum[4]);
    endproperty
    a_mul: assert property (p_mul) else $error("multiply wrong");
    property p_cmp;
        rip && sub == 2'h3 && cfg_r[11] |-> rippleCarryOut == (a != b);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare wrong");
    sequence s_upWr;
        cfg_r[0] && !rip && aIn[4] && gate && !(apbWr && paddr == 8'h04);
    endsequence
    sequence s_same;
        cfg_r[0] && !rip && a == $past(a);
    endsequence
    property p_upWr;
        s_upWr ##1 s_same |-> tableOut[3:2] == $past(writeDataInputs[3:2]);
    endproperty
    a_upWr: assert property (p_upWr) else $error("upper write lost");
endmodule // lut_datapath_props

bind lut_datapath lut_datapath_props lut_datapath_props_inst (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .aIn(aIn), .bIn(bIn),
    .writeDataInputs(writeDataInputs), .fastSideInput(fastSideInput),
    .rippleCarryIn(rippleCarryIn), .tableOut(tableOut),
    .rippleCarryOut(rippleCarryOut));

// ### fabric_model.sv
// Surrounding routing: operand buses and bank-decoded write gate
`timescale 1ns/1ps
module fabric_model (
    // From the bench
    input wire        six,
    input wire        memMode,
    input wire        hiAddr,
    input wire [4:0]  opA,
    input wire [4:0]  opB,
    input wire        sideIn,
    // To the datapath
    output wire [4:0] aIn,
    output wire [4:0] bIn,
    output wire       fastSideInput
);
    // address and enables shared bit for bit only when six is set
    assign aIn = opA;
    assign bIn = six ? opA : opB;
    assign fastSideInput = memMode ? !hiAddr : sideIn;
endmodule // fabric_model

// ### tb_lut_datapath.sv
// Self-checking bench for the table datapath
`timescale 1ns/1ps
module tb_lut_datapath;
    typedef struct packed {
        logic [13:0] cfg;
        logic [4:0]  a;
        logic [4:0]  b;
        logic        s;
        logic        c;
        logic [3:0]  t;
        logic        co;
    } row_t;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    logic        ref_clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    wire         pready;
    wire         pslverr;
    wire  [31:0] prdata;
    wire  [4:0]  aIn;
    wire  [4:0]  bIn;
    wire         fastSideInput;
    wire  [3:0]  tableOut;
    wire         rippleCarryOut;
    wire         output4;
    logic [3:0]  wd;
    logic        carry;
    logic [4:0]  opA;
    logic [4:0]  opB;
    logic        six;
    logic        memMode;
    logic        hiAddr;
    logic        side;
    logic [31:0] rd;
    logic        er;
    int          failCount = 0;
    int          checksDone = 0;
    row_t        rows [0:14] = '{
        '{14'h00a0, 5'h01, 5'h00, 1'b1, 1'b0, 4'he, 1'b0},
        '{14'h00a0, 5'h00, 5'h02, 1'b0, 1'b0, 4'h7, 1'b0},
        '{14'h00c0, 5'h01, 5'h02, 1'b1, 1'b0, 4'hb, 1'b0},
        '{14'h01c0, 5'h01, 5'h02, 1'b1, 1'b0, 4'hd, 1'b0},
        '{14'h0040, 5'h01, 5'h02, 1'b1, 1'b0, 4'hd, 1'b0},
        '{14'h0c04, 5'h07, 5'h09, 1'b0, 1'b0, 4'h1, 1'b1},
        '{14'h0e04, 5'h13, 5'h05, 1'b0, 1'b0, 4'hd, 1'b0},
        '{14'h0804, 5'h00, 5'h00, 1'b0, 1'b1, 4'h1, 1'b0},
        '{14'h0a04, 5'h01, 5'h10, 1'b0, 1'b0, 4'h2, 1'b0},
        '{14'h000c, 5'h0f, 5'h00, 1'b0, 1'b0, 4'h0, 1'b0},
        '{14'h000c, 5'h10, 5'h00, 1'b0, 1'b0, 4'hf, 1'b0},
        '{14'h0e14, 5'h16, 5'h0b, 1'b0, 1'b0, 4'h1, 1'b1},
        '{14'h0e14, 5'h06, 5'h0b, 1'b0, 1'b0, 4'h6, 1'b0},
        '{14'h0c1c, 5'h05, 5'h05, 1'b0, 1'b0, 4'h0, 1'b0},
        '{14'h081c, 5'h05, 5'h04, 1'b0, 1'b0, 4'h1, 1'b1}};

    lut_datapath lut_datapath_inst (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .aIn(aIn), .bIn(bIn),
        .writeDataInputs(wd), .fastSideInput(fastSideInput),
        .rippleCarryIn(carry), .tableOut(tableOut), .output4(output4),
        .rippleCarryOut(rippleCarryOut));
    fabric_model fabric_model_inst (
        .six(six), .memMode(memMode), .hiAddr(hiAddr), .opA(opA), .opB(opB),
        .sideIn(side), .aIn(aIn), .bIn(bIn), .fastSideInput(fastSideInput));
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Waits on pready with no fixed count; the watchdog ends a hang
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task wr(input logic h, input logic [4:0] x, input logic [4:0] y, input logic [3:0] d);
        @(posedge ref_clk);
        {hiAddr, opA, opB, wd} <= {h, x, y, d};
        @(posedge ref_clk);
        opA <= {1'b0, x[3:0]};
        opB <= {1'b0, y[3:0]};
        @(negedge ref_clk);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // Stimulus
    // --------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        failCount++;
        summarize;
    end
    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite, six, memMode, hiAddr, side, carry} = 8'h00;
        {paddr, pwdata, wd, opA, opB} = 54'h0;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        apb(1'b1, 8'h04, 32'haaaaaaaa);
        apb(1'b1, 8'h08, 32'hcccccccc);
        foreach (rows[i]) begin
            apb(1'b1, 8'h00, {18'h0, rows[i].cfg});
            @(posedge ref_clk);
            {opA, opB, side, carry} <= {rows[i].a, rows[i].b, rows[i].s, rows[i].c};
            @(negedge ref_clk);
            chk({rippleCarryOut, tableOut}, {rows[i].co, rows[i].t});
        end
        $display("table rows done");
        apb(1'b1, 8'h00, 32'h000000a0);
        @(posedge ref_clk);
        {six, opA, side} <= {1'b1, 5'h02, 1'b1};
        @(negedge ref_clk);
        chk(tableOut[1], 1'b0);
        @(posedge ref_clk);
        side <= 1'b0;
        @(negedge ref_clk);
        chk(tableOut[1], 1'b1);
        $display("six input done");
        @(posedge ref_clk);
        {rstn, six} <= 2'b00;
        @(negedge ref_clk);
        chk(tableOut, 4'h0);
        @(posedge ref_clk);
        rstn <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 8'h10, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        $display("reset and bus done");
        apb(1'b1, 8'h00, 32'h00000083);
        @(posedge ref_clk);
        memMode <= 1'b1;
        wr(1'b0, 5'h15, 5'h15, 4'h9);
        chk(tableOut, 4'h9);
        wr(1'b1, 5'h15, 5'h15, 4'h6);
        chk(tableOut, 4'h9);
        wr(1'b0, 5'h15, 5'h05, 4'h6);
        chk(tableOut, 4'h5);
        wr(1'b0, 5'h05, 5'h15, 4'h6);
        chk(tableOut, 4'h6);
        apb(1'b1, 8'h00, 32'h00002083);
        wr(1'b0, 5'h15, 5'h15, 4'h9);
        chk(tableOut, 4'h6);
        apb(1'b1, 8'h00, 32'h00000087);
        wr(1'b0, 5'h15, 5'h15, 4'h9);
        apb(1'b1, 8'h00, 32'h00000083);
        @(negedge ref_clk);
        chk(tableOut, 4'h6);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h00000083);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h00000036);
        $display("memory done");
        apb(1'b1, 8'h00, 32'h00001004);
        @(posedge ref_clk);
        {opA, opB, carry} <= {5'h0f, 5'h01, 1'b0};
        @(negedge ref_clk);
        chk({output4, rippleCarryOut, tableOut}, {2'b10, 4'h0});
        $display("carry routing done");
        summarize;
    end
endmodule // tb_lut_datapath
